// file: core/asf_pkg.sv
// asf_pkg: register map, command fields, operations and reset values of
// the alu status flag block.
// assumes a 32-bit apb register bus and an 8-bit datapath.
`default_nettype none
package asf_pkg;

	// ==================================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CMD    = 8'h00;
	localparam logic [7:0] ADDR_ACCUM  = 8'h04;
	localparam logic [7:0] ADDR_FLAGS  = 8'h08;
	localparam logic [7:0] ADDR_PTR    = 8'h0c;
	localparam logic [7:0] ADDR_CFG    = 8'h10;
	localparam logic [7:0] ADDR_FILE0  = 8'h20;
	localparam int         FILE_COUNT  = 4;

	// ==================================================================
	// command word fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_OP_W     = 5;
	localparam int CMD_DEST     = 5;
	localparam int CMD_TGT_FLAG = 6;
	localparam int CMD_INDEXED  = 7;
	localparam int CMD_LIT_LSB  = 8;
	localparam int CMD_IDX_LSB  = 16;

	// ==================================================================
	// flag bit positions and config bits
	localparam int FLAG_C  = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z  = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N  = 4;
	localparam int CFG_EXT = 0;
	localparam int CFG_REF = 1;

	// ==================================================================
	// reset values
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [7:0]  ACCUM_RST = 8'h00;
	localparam logic [7:0]  FILE_RST  = 8'h00;
	localparam logic [11:0] PTR_RST   = 12'h000;

	typedef enum logic [4:0] {
		OP_ADD_FILE  = 5'h00, OP_ADD_LIT   = 5'h01,
		OP_LIT_MINUS = 5'h02, OP_FILE_MINUS = 5'h03,
		OP_AND       = 5'h04, OP_IOR       = 5'h05,
		OP_XOR       = 5'h06, OP_CLEAR     = 5'h07,
		OP_BIT_CLR   = 5'h08, OP_BIT_SET   = 5'h09,
		OP_NIBBLE    = 5'h0a, OP_F2F_MOVE  = 5'h0b,
		OP_A2F_MOVE  = 5'h0c, OP_ROT_RIGHT = 5'h0d,
		OP_ROT_LEFT  = 5'h0e, OP_PTR_INC   = 5'h0f,
		OP_PTR_DEC   = 5'h10
	} asf_op_type;

endpackage
`default_nettype wire

// file: core/asf_flag_alu.sv
// asf_flag_alu: combinational alu that computes the result and the next
// value of the five arithmetic flags for one operation.
// assumes operands are stable for the cycle in which the result is used.
`timescale 1ns/1ps
`default_nettype none
module asf_flag_alu (
	// operation and operands
	input  wire asf_pkg::asf_op_type op,
	input  wire logic [7:0]          src,
	input  wire logic [7:0]          accum,
	input  wire logic [7:0]          lit,
	input  wire logic [4:0]          flags_in,
	// answers
	output logic [7:0]               result,
	output logic [4:0]               flags_out,
	output logic                     touch
);
	logic [7:0] opa;
	logic [7:0] opb;
	logic       cin;
	logic       arith;
	logic       logic_op;
	logic [8:0] sum;
	logic [4:0] low_sum;

	// ==================================================================
	// adder: subtraction adds the two's complement of the accumulator
	assign sum     = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
	assign low_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};

	always_comb begin
		opa       = src;
		opb       = accum;
		cin       = 1'b0;
		arith     = 1'b0;
		logic_op  = 1'b0;
		result    = src;
		flags_out = flags_in;
		touch     = 1'b0;
		case (op)
			asf_pkg::OP_ADD_FILE: arith = 1'b1;
			asf_pkg::OP_ADD_LIT: begin
				opa   = lit;
				arith = 1'b1;
			end
			asf_pkg::OP_LIT_MINUS: begin
				opa   = lit;
				opb   = ~accum;
				cin   = 1'b1;
				arith = 1'b1;
			end
			asf_pkg::OP_FILE_MINUS: begin
				opb   = ~accum;
				cin   = 1'b1;
				arith = 1'b1;
			end
			asf_pkg::OP_AND: begin
				result   = src & accum;
				logic_op = 1'b1;
			end
			asf_pkg::OP_IOR: begin
				result   = src | accum;
				logic_op = 1'b1;
			end
			asf_pkg::OP_XOR: begin
				result   = src ^ accum;
				logic_op = 1'b1;
			end
			asf_pkg::OP_CLEAR: begin
				result                   = 8'h00;
				flags_out[asf_pkg::FLAG_Z] = 1'b1;
				touch                    = 1'b1;
			end
			// bit, nibble and move operations never touch the flags
			asf_pkg::OP_BIT_CLR: result = src & ~(8'h01 << lit[2:0]);
			asf_pkg::OP_BIT_SET: result = src | (8'h01 << lit[2:0]);
			asf_pkg::OP_NIBBLE: result = {src[3:0], src[7:4]};
			asf_pkg::OP_A2F_MOVE: result = accum;
			asf_pkg::OP_ROT_RIGHT: begin
				result = {flags_in[asf_pkg::FLAG_C], src[7:1]};
				flags_out[asf_pkg::FLAG_C]  = src[0];
				flags_out[asf_pkg::FLAG_DC] = src[4];
				logic_op = 1'b1;
			end
			asf_pkg::OP_ROT_LEFT: begin
				result = {src[6:0], flags_in[asf_pkg::FLAG_C]};
				flags_out[asf_pkg::FLAG_C]  = src[7];
				flags_out[asf_pkg::FLAG_DC] = src[3];
				logic_op = 1'b1;
			end
			default: result = src;
		endcase
		if (arith) begin
			result    = sum[7:0];
			flags_out = {sum[7],
				(opa[7] == opb[7]) && (sum[7] != opa[7]),
				sum[7:0] == 8'h00,
				low_sum[4],
				sum[8]};
			touch     = 1'b1;
		end
		if (logic_op) begin
			flags_out[asf_pkg::FLAG_N] = result[7];
			flags_out[asf_pkg::FLAG_Z] = result == 8'h00;
			touch = 1'b1;
		end
	end
endmodule // asf_flag_alu
`default_nettype wire

// file: core/asf_status_core.sv
// asf_status_core: apb slave that executes one alu command per write to
// the command register and keeps the alu flag register.
// assumes an apb master on pclk; commands take effect on the write edge.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asf_status_core #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// flag register, for the rest of the core
	output logic [7:0]             alu_flag_register
);
	logic [7:0]  file_q [asf_pkg::FILE_COUNT];
	logic [7:0]  accum_q;
	logic [11:0] ptr_q;
	logic        ext_cfg_q;
	logic        refused_q;
	logic [31:0] cmd_q;
	logic [31:0] rdata_d;
	logic        hit_d;
	logic        access;
	logic        wr_edge;
	logic        cmd_wr;
	logic        refused;
	logic        exec;
	asf_pkg::asf_op_type op;
	logic [7:0]  lit;
	logic        tgt_flag;
	logic        dest_bit;
	logic [1:0]  fidx;
	logic [1:0]  didx;
	logic        implicit;
	logic        ptr_op;
	logic        to_target;
	logic        to_accum;
	logic [7:0]  src;
	logic [7:0]  result;
	logic [4:0]  flags_next;
	logic        touch;
	logic [7:0]  waddr8;

	// ==================================================================
	// command decode
	assign access  = psel && penable && !pready;
	assign wr_edge = psel && penable && pready && pwrite;
	assign waddr8  = 8'(paddr);
	assign cmd_wr  = wr_edge && waddr8 == asf_pkg::ADDR_CMD;
	assign op      = asf_pkg::asf_op_type'(pwdata[asf_pkg::CMD_OP_LSB +:
		asf_pkg::CMD_OP_W]);
	assign lit      = pwdata[asf_pkg::CMD_LIT_LSB +: 8];
	assign tgt_flag = pwdata[asf_pkg::CMD_TGT_FLAG];
	assign dest_bit = pwdata[asf_pkg::CMD_DEST];
	// indexed offset is refused unless the extended set is configured
	assign refused  = cmd_wr && pwdata[asf_pkg::CMD_INDEXED] && !ext_cfg_q;
	assign exec     = cmd_wr && !refused;
	assign fidx     = pwdata[asf_pkg::CMD_INDEXED] ?
		ptr_q[1:0] + lit[1:0] : pwdata[asf_pkg::CMD_IDX_LSB +: 2];
	assign didx     = op == asf_pkg::OP_F2F_MOVE ? lit[1:0] : fidx;
	assign implicit = op inside {asf_pkg::OP_CLEAR, asf_pkg::OP_BIT_CLR,
		asf_pkg::OP_BIT_SET, asf_pkg::OP_F2F_MOVE, asf_pkg::OP_A2F_MOVE};
	assign ptr_op   = op inside {asf_pkg::OP_PTR_INC, asf_pkg::OP_PTR_DEC};
	assign to_target = exec && !ptr_op && (dest_bit || implicit);
	assign to_accum  = exec && !ptr_op && !dest_bit && !implicit;
	// the flag register is an ordinary source operand
	assign src = (tgt_flag && op != asf_pkg::OP_F2F_MOVE) ?
		alu_flag_register : file_q[fidx];

	asf_flag_alu u_alu (
		.op        (op),
		.src       (src),
		.accum     (accum_q),
		.lit       (lit),
		.flags_in  (alu_flag_register[4:0]),
		.result    (result),
		.flags_out (flags_next),
		.touch     (touch)
	);

	// ==================================================================
	// flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alu_flag_register <= asf_pkg::FLAGS_RST;
		end else if (wr_edge && waddr8 == asf_pkg::ADDR_FLAGS) begin
			alu_flag_register <= {3'b000, pwdata[4:0]};
		end else if (to_target && tgt_flag) begin
			// a flag-changing op wins over its own data write
			alu_flag_register <= {3'b000,
				touch ? flags_next : result[4:0]};
		end else if (exec) begin
			alu_flag_register <= {3'b000, flags_next};
		end
	end

	// ==================================================================
	// accumulator, files and pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accum_q <= asf_pkg::ACCUM_RST;
		end else if (wr_edge && waddr8 == asf_pkg::ADDR_ACCUM) begin
			accum_q <= pwdata[7:0];
		end else if (to_accum) begin
			accum_q <= result;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < asf_pkg::FILE_COUNT; gi++) begin : g_file
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					file_q[gi] <= asf_pkg::FILE_RST;
				end else if (wr_edge && waddr8 ==
					asf_pkg::ADDR_FILE0 + 8'(gi * 4)) begin
					file_q[gi] <= pwdata[7:0];
				end else if (to_target && !tgt_flag && didx == 2'(gi)) begin
					file_q[gi] <= result;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= asf_pkg::PTR_RST;
		end else if (wr_edge && waddr8 == asf_pkg::ADDR_PTR) begin
			ptr_q <= pwdata[11:0];
		end else if (exec && op == asf_pkg::OP_PTR_INC) begin
			ptr_q <= ptr_q + 12'h001;
		end else if (exec && op == asf_pkg::OP_PTR_DEC) begin
			ptr_q <= ptr_q - 12'h001;
		end
	end

	// ==================================================================
	// config: refused flag is set-wins over its write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_cfg_q <= 1'b0;
			refused_q <= 1'b0;
			cmd_q     <= 32'h0000_0000;
		end else begin
			if (wr_edge && waddr8 == asf_pkg::ADDR_CFG) begin
				ext_cfg_q <= pwdata[asf_pkg::CFG_EXT];
			end
			if (refused) begin
				refused_q <= 1'b1;
			end else if (wr_edge && waddr8 == asf_pkg::ADDR_CFG &&
				pwdata[asf_pkg::CFG_REF]) begin
				refused_q <= 1'b0;
			end
			if (cmd_wr) begin
				cmd_q <= pwdata;
			end
		end
	end

	// ==================================================================
	// apb answer: one wait state so prdata and pready come from flops
	always_comb begin
		rdata_d = 32'h0000_0000;
		hit_d   = 1'b1;
		if (waddr8 == asf_pkg::ADDR_CMD) begin
			rdata_d = cmd_q;
		end else if (waddr8 == asf_pkg::ADDR_ACCUM) begin
			rdata_d = {24'h000000, accum_q};
		end else if (waddr8 == asf_pkg::ADDR_FLAGS) begin
			rdata_d = {24'h000000, alu_flag_register};
		end else if (waddr8 == asf_pkg::ADDR_PTR) begin
			rdata_d = {20'h00000, ptr_q};
		end else if (waddr8 == asf_pkg::ADDR_CFG) begin
			rdata_d = {30'h00000000, refused_q, ext_cfg_q};
		end else if (waddr8[7:4] == asf_pkg::ADDR_FILE0[7:4] &&
			waddr8[3] == 1'b0 && waddr8[1:0] == 2'b00) begin
			rdata_d = {24'h000000, file_q[waddr8[3:2]]};
		end else begin
			hit_d = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= access;
			pslverr <= access && !hit_d;
			if (access && !pwrite) begin
				prdata <= rdata_d;
			end
		end
	end

	// ==================================================================
	// checks
	AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		alu_flag_register[7:5] == 3'b000)
		else $error("reserved flag bits not zero");

	AST_CLEAR_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == asf_pkg::OP_CLEAR && tgt_flag |=>
		alu_flag_register == {3'b000, $past(alu_flag_register[4:3]),
		1'b1, $past(alu_flag_register[1:0])})
		else $error("clear of flag register wrong pattern");

	AST_NOFLAG_OPS: assert property (@(posedge pclk) disable iff (!presetn)
		exec && !tgt_flag && op inside {asf_pkg::OP_BIT_CLR,
		asf_pkg::OP_BIT_SET, asf_pkg::OP_NIBBLE, asf_pkg::OP_F2F_MOVE,
		asf_pkg::OP_A2F_MOVE} |=> $stable(alu_flag_register))
		else $error("move or bit op changed flags");

	AST_PTR_NOFLAG: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == asf_pkg::OP_PTR_INC |=>
		$stable(alu_flag_register) && ptr_q == $past(ptr_q) + 12'h001)
		else $error("pointer increment wrong or touched flags");

	AST_ADD_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == asf_pkg::OP_ADD_FILE && !tgt_flag |=>
		alu_flag_register[2] == ($past(src + accum_q) == 8'h00) &&
		alu_flag_register[4] == $past(8'(src + accum_q)) >> 7)
		else $error("zero or negative flag wrong after add");

	AST_SUB_BORROW: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == asf_pkg::OP_FILE_MINUS && !tgt_flag |=>
		alu_flag_register[0] == ($past(src) >= $past(accum_q)))
		else $error("carry does not mean no borrow");

	AST_INDEX_REFUSED: assert property (@(posedge pclk)
		disable iff (!presetn)
		refused |=> refused_q && $stable(alu_flag_register)
		&& $stable(accum_q))
		else $error("indexed command ran without extended config");

	AST_DEST_ACCUM: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == asf_pkg::OP_ADD_LIT && !dest_bit |=>
		accum_q == $past(8'(lit + accum_q)))
		else $error("accumulator not written with the sum");

	AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		access |=> pready ##1 !pready)
		else $error("apb answer not after one wait state");
endmodule // asf_status_core
`default_nettype wire

// file: tb/alu_status_flags_test.sv
// alu_status_flags_test: self-checking bench for asf_status_core.
// assumes the core answers every apb access by itself within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module alu_status_flags_test;
	// ==================================================================
	// signals
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  flags;
	logic [31:0] rd;
	logic        err;
	int          n_fail;
	int          comparisons;
	int          cycles;

	// ops table: accumulator, file0, literal, flags before, result, flags
	asf_pkg::asf_op_type ops [13] = '{asf_pkg::OP_ADD_FILE,
		asf_pkg::OP_ADD_FILE, asf_pkg::OP_ADD_LIT, asf_pkg::OP_FILE_MINUS,
		asf_pkg::OP_FILE_MINUS, asf_pkg::OP_LIT_MINUS, asf_pkg::OP_LIT_MINUS,
		asf_pkg::OP_AND, asf_pkg::OP_XOR, asf_pkg::OP_IOR,
		asf_pkg::OP_ROT_RIGHT, asf_pkg::OP_ROT_LEFT, asf_pkg::OP_ROT_RIGHT};
	logic [7:0] va [13] = '{8'h7f, 8'hff, 8'h08, 8'h03, 8'h05, 8'h01, 8'h05,
		8'h0f, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
	logic [7:0] vf [13] = '{8'h01, 8'h01, 8'h00, 8'h05, 8'h03, 8'h00, 8'h00,
		8'hf0, 8'h80, 8'h80, 8'h11, 8'h88, 8'h00};
	logic [7:0] vl [13] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h80, 8'h05,
		8'hf0, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
	logic [7:0] vp [13] = '{8'h05, 8'h18, 8'h1d, 8'h1c, 8'h0f, 8'h16, 8'h18,
		8'h0b, 8'h13, 8'h00, 8'h1c, 8'h10, 8'h01};
	logic [7:0] vr [13] = '{8'h80, 8'h00, 8'h10, 8'h02, 8'hfe, 8'h7f, 8'h00,
		8'h00, 8'h00, 8'h80, 8'h08, 8'h10, 8'h80};
	logic [7:0] vx [13] = '{8'h1a, 8'h07, 8'h02, 8'h03, 8'h10, 8'h09, 8'h07,
		8'h0f, 8'h07, 8'h10, 8'h0b, 8'h03, 8'h10};

	asf_status_core DUT (
		.pclk              (pclk),
		.presetn           (presetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.alu_flag_register (flags)
	);

	// ==================================================================
	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			results();
		end
	end

	// ==================================================================
	// helpers
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// request held until pready is sampled high; data taken at that edge
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd  = prdata;
		err = pslverr;
		if (n == 20) begin
			n_fail++;
			results();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(string what, logic [7:0] a, logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask

	function automatic logic [31:0] cmd(asf_pkg::asf_op_type op, logic dst,
		logic tgt, logic ix, logic [7:0] lit, logic [1:0] fi);
		cmd = 32'h0;
		cmd[asf_pkg::CMD_OP_LSB +: 5] = op;
		cmd[asf_pkg::CMD_DEST] = dst;
		cmd[asf_pkg::CMD_TGT_FLAG] = tgt;
		cmd[asf_pkg::CMD_INDEXED] = ix;
		cmd[asf_pkg::CMD_LIT_LSB +: 8] = lit;
		cmd[asf_pkg::CMD_IDX_LSB +: 2] = fi;
	endfunction

	task automatic setup(logic [7:0] acc, logic [7:0] f0, logic [7:0] fl);
		wr(asf_pkg::ADDR_ACCUM, {24'h0, acc});
		wr(asf_pkg::ADDR_FILE0, {24'h0, f0});
		wr(asf_pkg::ADDR_FLAGS, {24'h0, fl});
	endtask

	// flags must be visible right after the executing edge
	task automatic run(logic [31:0] c, logic [7:0] ef);
		wr(asf_pkg::ADDR_CMD, c);
		#1;
		check("flag port", {24'h0, flags}, {24'h0, ef});
		rdchk("flag reg", asf_pkg::ADDR_FLAGS, {24'h0, ef});
	endtask

	// ==================================================================
	// scenarios
	task automatic t_reset();
		rdchk("flags rst", asf_pkg::ADDR_FLAGS, 32'h0);
		rdchk("accum rst", asf_pkg::ADDR_ACCUM, 32'h0);
		rdchk("cfg rst", asf_pkg::ADDR_CFG, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check("slverr", {31'h0, err}, 32'h1);
		wr(asf_pkg::ADDR_FLAGS, 32'hff);
		rdchk("upper bits", asf_pkg::ADDR_FLAGS, 32'h1f);
		$display("test reset done");
	endtask

	task automatic t_alu();
		for (int i = 0; i < 13; i++) begin
			setup(va[i], vf[i], vp[i]);
			run(cmd(ops[i], 1'b0, 1'b0, 1'b0, vl[i], 2'd0), vx[i]);
			rdchk("accum", asf_pkg::ADDR_ACCUM, {24'h0, vr[i]});
			rdchk("file kept", asf_pkg::ADDR_FILE0, {24'h0, vf[i]});
		end
		setup(8'h7f, 8'h01, 8'h05);
		run(cmd(asf_pkg::OP_ADD_FILE, 1'b1, 1'b0, 1'b0, 8'h0, 2'd0), 8'h1a);
		rdchk("file dest", asf_pkg::ADDR_FILE0, 32'h80);
		rdchk("accum kept", asf_pkg::ADDR_ACCUM, 32'h7f);
		$display("test alu done");
	endtask

	task automatic t_flagreg();
		setup(8'h01, 8'h00, 8'h1b);
		run(cmd(asf_pkg::OP_CLEAR, 1'b1, 1'b1, 1'b0, 8'h0, 2'd0), 8'h1f);
		wr(asf_pkg::ADDR_FLAGS, 32'h0);
		run(cmd(asf_pkg::OP_ADD_FILE, 1'b1, 1'b1, 1'b0, 8'h0, 2'd0), 8'h00);
		run(cmd(asf_pkg::OP_BIT_SET, 1'b1, 1'b1, 1'b0, 8'h3, 2'd0), 8'h08);
		run(cmd(asf_pkg::OP_BIT_SET, 1'b1, 1'b1, 1'b0, 8'h6, 2'd0), 8'h08);
		run(cmd(asf_pkg::OP_BIT_CLR, 1'b1, 1'b1, 1'b0, 8'h3, 2'd0), 8'h00);
		wr(asf_pkg::ADDR_ACCUM, 32'h13);
		run(cmd(asf_pkg::OP_A2F_MOVE, 1'b1, 1'b1, 1'b0, 8'h0, 2'd0), 8'h13);
		wr(asf_pkg::ADDR_FILE0 + 8'h04, 32'h0a);
		run(cmd(asf_pkg::OP_F2F_MOVE, 1'b1, 1'b1, 1'b0, 8'h0, 2'd1), 8'h0a);
		setup(8'h00, 8'h3c, 8'h15);
		run(cmd(asf_pkg::OP_NIBBLE, 1'b1, 1'b0, 1'b0, 8'h0, 2'd0), 8'h15);
		rdchk("swapped", asf_pkg::ADDR_FILE0, 32'hc3);
		wr(asf_pkg::ADDR_PTR, 32'h0ff);
		run(cmd(asf_pkg::OP_PTR_INC, 1'b0, 1'b0, 1'b0, 8'h0, 2'd0), 8'h15);
		rdchk("ptr up", asf_pkg::ADDR_PTR, 32'h100);
		wr(asf_pkg::ADDR_PTR, 32'h000);
		run(cmd(asf_pkg::OP_PTR_DEC, 1'b0, 1'b0, 1'b0, 8'h0, 2'd0), 8'h15);
		rdchk("ptr down", asf_pkg::ADDR_PTR, 32'hfff);
		$display("test flag register done");
	endtask

	task automatic t_ext();
		setup(8'h01, 8'h00, 8'h1f);
		wr(asf_pkg::ADDR_FILE0 + 8'h08, 32'h20);
		wr(asf_pkg::ADDR_PTR, 32'h001);
		run(cmd(asf_pkg::OP_ADD_FILE, 1'b0, 1'b0, 1'b1, 8'h1, 2'd0), 8'h1f);
		rdchk("not run", asf_pkg::ADDR_ACCUM, 32'h01);
		rdchk("refused", asf_pkg::ADDR_CFG, 32'h2);
		wr(asf_pkg::ADDR_CFG, 32'h3);
		rdchk("ext on", asf_pkg::ADDR_CFG, 32'h1);
		run(cmd(asf_pkg::OP_ADD_FILE, 1'b0, 1'b0, 1'b1, 8'h1, 2'd0), 8'h00);
		rdchk("indexed", asf_pkg::ADDR_ACCUM, 32'h21);
		$display("test extended mode done");
	endtask

	task automatic results();
		$display("checks %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==================================================================
	// main sequence
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		n_fail  = 0;
		comparisons = 0;
		cycles  = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_alu();
		t_flagreg();
		t_ext();
		results();
	end
endmodule // alu_status_flags_test
`default_nettype wire
